//--- design/arsc_pkg.sv
// package of constants and types for the acquisition run/stop controller
`default_nettype none
package arsc_pkg;
   // ==========================================================
   // register offsets (plain port, word addresses)
   localparam logic [3:0] OFS_RUN_CTRL = 4'h0;
   localparam logic [3:0] OFS_STOP_SEL = 4'h1;
   localparam logic [3:0] OFS_ACQ_MODE = 4'h2;
   localparam logic [3:0] OFS_AVG_CNT = 4'h3;
   localparam logic [3:0] OFS_ENV_CNT = 4'h4;
   localparam logic [3:0] OFS_ACQ_COUNT = 4'h5;
   localparam logic [3:0] OFS_STATUS = 4'h6;
   // ==========================================================
   // field positions and reset values
   localparam int RUN_BIT = 0;
   localparam int STOPSEL_BIT = 0;
   localparam logic [1:0] RST_ACQ_MODE = 2'h0;
   localparam logic [9:0] RST_AVG_CNT = 10'h010;
   localparam logic [9:0] RST_ENV_CNT = 10'h010;
   localparam logic [9:0] ENV_INFINITE_LIMIT = 10'h201;
   // ==========================================================
   // acquisition modes and stop condition
   typedef enum logic [1:0] {
      MODE_SAMPLE = 2'h0,
      MODE_AVERAGE = 2'h1,
      MODE_ENVELOPE = 2'h2
   } arsc_mode_t;
   typedef enum logic {
      STOP_TOGGLE = 1'b0,
      STOP_ONESHOT = 1'b1
   } arsc_stop_t;
endpackage : arsc_pkg
`default_nettype wire

//--- design/arsc_sync.sv
// three-flop synchroniser with agreement-based edge for the panel toggle
`timescale 1ns/1ps
`default_nettype none
module arsc_sync (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // pin side
   input wire logic pin_in,
   // synchronised side
   output logic level,
   output logic rise
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;
   logic lvl_d;

   // ==========================================================
   // s1 only feeds s2; a change counts once s2 and s3 agree
   assign lvl_d = (s2_q == s3_q) ? s2_q : lvl_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl_q <= 1'b0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end
   assign level = lvl_q;
   assign rise = lvl_d & ~lvl_q;
endmodule : arsc_sync
`default_nettype wire

//--- design/arsc_top.sv
// acquisition run/stop controller: register port, panel toggle, one-shot stop
//
// Summary of operation
// [R1] Writing zero to the run control halts acquisition.
// [R2] Writing a nonzero value to the run control starts acquisition and display.
// [R3] A run request restarts any partial averaging or enveloping sequence, discarding old data.
// [R4] Every run request clears the acquired waveform count to zero.
// [R5] Reading the run control returns 1 while running and 0 while stopped.
// [R6] The run control and the panel toggle drive one shared running state.
// [R7] In toggle stop mode only a user run/stop action changes the running state.
// [R8] In one-shot mode the block stops itself once the active mode is satisfied.
// [R9] One-shot sample mode stops after the waveform from one trigger.
// [R10] One-shot averaging stops after the full programmed count of waveforms.
// [R11] In one-shot mode a stop write or a toggle press still ends acquisition early.
// [R12] Software programs average and envelope counts as powers of two from 2 to 512.
// [R13] One-shot envelope with unlimited count stops after at most 513 acquisitions.
// [R14] A toggle press inverts the running state; starting this way also restarts and clears.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module arsc_top #(
   parameter int COUNT_W = 16
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // register port
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   // front panel
   input wire logic PANEL_TOGGLE,
   // acquisition engine
   input wire logic WFM_DONE,
   output logic ACQ_RUN,
   output logic SEQ_RESTART,
   output logic [COUNT_W-1:0] ACQ_COUNT
);

   // ==========================================================
   // register map, word offsets on the plain port
   //   0 run control: write nonzero to run, zero to stop; reads the running state
   //   1 stop condition: bit 0 low for toggle control, high for one-shot capture
   //   2 acquisition mode: sample, average or envelope; code 3 behaves as sample
   //   3 average count, ten bits, meant as a power of two from 2 to 512
   //   4 envelope count, ten bits, zero means unlimited
   //   5 acquired waveform count, read only, low sixteen bits
   //   6 status: bit 0 running, bit 1 debounced panel level
   // writes to other offsets are dropped and reads of them return zero
   // the count settings are not checked; a bad value only moves the stop point

   // ==========================================================
   // decode helpers
   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic run_q;
   logic run_d;
   logic stop_sel_q;
   logic [1:0] mode_q;
   logic [9:0] avg_q;
   logic [9:0] env_q;
   logic [COUNT_W-1:0] cnt_q;
   logic [COUNT_W-1:0] cnt_d;
   logic [COUNT_W-1:0] seq_q;
   logic [COUNT_W-1:0] seq_d;
   logic restart_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic panel_level;
   logic panel_press;

   // ==========================================================
   // panel toggle synchroniser
   arsc_sync u_sync (
      .clk(CLK),
      .reset(RESET),
      .pin_in(PANEL_TOGGLE),
      .level(panel_level),
      .rise(panel_press)
   );

   // ==========================================================
   // write decode
   wire wr_run = WR & hit(ADDR, arsc_pkg::OFS_RUN_CTRL);
   wire wr_stopsel = WR & hit(ADDR, arsc_pkg::OFS_STOP_SEL);
   wire wr_mode = WR & hit(ADDR, arsc_pkg::OFS_ACQ_MODE);
   wire wr_avg = WR & hit(ADDR, arsc_pkg::OFS_AVG_CNT);
   wire wr_env = WR & hit(ADDR, arsc_pkg::OFS_ENV_CNT);
   wire wr_nonzero = (WDATA != 16'h0000);
   wire is_oneshot = (stop_sel_q == arsc_pkg::STOP_ONESHOT);

   // ==========================================================
   // completion target of the one-shot sequence
   // infinite envelope is a zero count; it is capped so one-shot always ends
   wire mode_avg = (mode_q == arsc_pkg::MODE_AVERAGE);
   wire mode_env = (mode_q == arsc_pkg::MODE_ENVELOPE);
   wire mode_smp = ~mode_avg & ~mode_env; // code 3 falls back to sample
   wire env_unlimited = (env_q == 10'h000);
   wire [9:0] env_target = env_unlimited ? arsc_pkg::ENV_INFINITE_LIMIT : env_q; // see [R13]
   wire [9:0] target = mode_avg ? avg_q : // see [R10]
                       mode_env ? env_target :
                       10'h001; // see [R9]
   wire [COUNT_W-1:0] seq_next = COUNT_W'(seq_q + 1'b1);
   wire seq_full = WFM_DONE & ({{(COUNT_W-10){1'b0}}, target} <= seq_next);

   // ==========================================================
   // run requests and stops; a run control write wins over a panel press in the same cycle
   wire start_wr = wr_run & wr_nonzero; // see [R2]
   wire stop_wr = wr_run & ~wr_nonzero; // see [R1]
   wire press_start = ~wr_run & panel_press & ~run_q; // see [R14]
   wire press_stop = ~wr_run & panel_press & run_q; // see [R14] [R11]
   wire run_request = start_wr | press_start; // see [R6]
   wire auto_stop = run_q & is_oneshot & seq_full; // see [R8] [R7]

   // ==========================================================
   // next running state; auto-stop never blocks a fresh run request
   always_comb begin
      run_d = run_q;
      if (run_request)
         run_d = 1'b1;
      else if (stop_wr | press_stop | auto_stop) // see [R11]
         run_d = 1'b0;
   end

   // ==========================================================
   // counters: run requests clear both the count and the sequence
   always_comb begin
      cnt_d = cnt_q;
      seq_d = seq_q;
      if (run_request) begin
         cnt_d = '0; // see [R4]
         seq_d = '0; // see [R3]
      end else if (run_q & WFM_DONE) begin
         cnt_d = COUNT_W'(cnt_q + 1'b1);
         seq_d = seq_next;
      end
   end

   // ==========================================================
   // running state; reset leaves the engine stopped
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET)
         run_q <= 1'b0;
      else
         run_q <= run_d;
   end

   // acquired waveform count seen by software
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

   // sequence position used for the one-shot target
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET)
         seq_q <= '0;
      else
         seq_q <= seq_d;
   end

   // restart pulse, one cycle after the request so the engine sees settled state
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET)
         restart_q <= 1'b0;
      else
         restart_q <= run_request; // see [R3]
   end

   // ==========================================================
   // settings; counts are trusted to be powers of two from 2 to 512
   // stop condition select, toggle control after reset
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET)
         stop_sel_q <= arsc_pkg::STOP_TOGGLE;
      else if (wr_stopsel)
         stop_sel_q <= WDATA[arsc_pkg::STOPSEL_BIT];
   end

   // acquisition mode
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET)
         mode_q <= arsc_pkg::RST_ACQ_MODE;
      else if (wr_mode)
         mode_q <= WDATA[1:0];
   end

   // average count
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET)
         avg_q <= arsc_pkg::RST_AVG_CNT; // see [R12]
      else if (wr_avg)
         avg_q <= WDATA[9:0];
   end

   // envelope count
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET)
         env_q <= arsc_pkg::RST_ENV_CNT;
      else if (wr_env)
         env_q <= WDATA[9:0];
   end

   // ==========================================================
   // read mux; unmapped offsets read zero
   always_comb begin
      rdata_d = 16'h0000;
      case (ADDR)
         arsc_pkg::OFS_RUN_CTRL: rdata_d = {15'h0000, run_q}; // see [R5]
         arsc_pkg::OFS_STOP_SEL: rdata_d = {15'h0000, stop_sel_q};
         arsc_pkg::OFS_ACQ_MODE: rdata_d = {14'h0000, mode_q};
         arsc_pkg::OFS_AVG_CNT: rdata_d = {6'h00, avg_q};
         arsc_pkg::OFS_ENV_CNT: rdata_d = {6'h00, env_q};
         arsc_pkg::OFS_ACQ_COUNT: rdata_d = cnt_q[15:0];
         arsc_pkg::OFS_STATUS: rdata_d = {14'h0000, panel_level, run_q};
         default: rdata_d = 16'h0000;
      endcase
      if (!RD)
         rdata_d = 16'h0000;
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET)
         rdata_q <= 16'h0000;
      else
         rdata_q <= rdata_d;
   end

   // ==========================================================
   // outputs
   assign RDATA = rdata_q;
   assign ACQ_RUN = run_q;
   assign SEQ_RESTART = restart_q;
   assign ACQ_COUNT = cnt_q;

   // ==========================================================
   // assertions
   a_stop_write: assert property (@(posedge CLK) disable iff (RESET)
      stop_wr |=> !ACQ_RUN) // see [R1]
      else $error("stop write did not halt acquisition");
   a_run_write: assert property (@(posedge CLK) disable iff (RESET)
      start_wr |=> ACQ_RUN && SEQ_RESTART) // see [R2]
      else $error("run write did not start acquisition");
   a_count_clear: assert property (@(posedge CLK) disable iff (RESET)
      run_request |=> ACQ_COUNT == '0) // see [R4]
      else $error("count not cleared on run request");
   a_read_state: assert property (@(posedge CLK) disable iff (RESET)
      (RD && ADDR == arsc_pkg::OFS_RUN_CTRL) |=> RDATA == {15'h0000, $past(run_q)}) // see [R5]
      else $error("run control read wrong");
   a_toggle_hold: assert property (@(posedge CLK) disable iff (RESET)
      (!is_oneshot && !wr_run && !panel_press) |=> $stable(ACQ_RUN)) // see [R7]
      else $error("running state changed without user action");
   a_press_invert: assert property (@(posedge CLK) disable iff (RESET)
      (panel_press && !wr_run) |=> ACQ_RUN != $past(ACQ_RUN)) // see [R14]
      else $error("panel press did not invert state");
   a_sample_once: assert property (@(posedge CLK) disable iff (RESET)
      (run_q && is_oneshot && mode_q == arsc_pkg::MODE_SAMPLE && WFM_DONE
       && !run_request) |=> !ACQ_RUN) // see [R9]
      else $error("one-shot sample did not stop after one waveform");
   a_avg_full: assert property (@(posedge CLK) disable iff (RESET)
      (run_q && is_oneshot && mode_q == arsc_pkg::MODE_AVERAGE && !WFM_DONE
       && !stop_wr && !panel_press) |=> ACQ_RUN) // see [R10]
      else $error("one-shot average stopped without a waveform");
   a_env_cap: assert property (@(posedge CLK) disable iff (RESET)
      (run_q && is_oneshot) |-> seq_q <= COUNT_W'(arsc_pkg::ENV_INFINITE_LIMIT)) // see [R13]
      else $error("one-shot sequence ran past its cap");

   // ==========================================================
   // restart pulse: one cycle wide and only after a run request, from either source
   a_restart_pulse: assert property (@(posedge CLK) disable iff (RESET)
      !run_request |=> !SEQ_RESTART) // see [R3]
      else $error("restart pulse without a run request");
   a_press_restart: assert property (@(posedge CLK) disable iff (RESET)
      press_start |=> ACQ_RUN && SEQ_RESTART && ACQ_COUNT == '0) // see [R14]
      else $error("panel start did not restart and clear");
   a_start_clear: assert property (@(posedge CLK) disable iff (RESET)
      start_wr |=> seq_q == '0) // see [R3]
      else $error("run write kept the old sequence");

   // ==========================================================
   // waveform count: steps once per waveform while running, frozen while stopped
   a_count_step: assert property (@(posedge CLK) disable iff (RESET)
      (run_q && WFM_DONE && !run_request)
      |=> ACQ_COUNT == COUNT_W'($past(ACQ_COUNT) + 1'b1)) // see [R4]
      else $error("count did not step on a waveform");
   a_count_idle: assert property (@(posedge CLK) disable iff (RESET)
      (!run_q && !run_request) |=> $stable(ACQ_COUNT)) // see [R4]
      else $error("count moved while stopped");
   a_read_count: assert property (@(posedge CLK) disable iff (RESET)
      (RD && ADDR == arsc_pkg::OFS_ACQ_COUNT) |=> RDATA == 16'($past(ACQ_COUNT))) // see [R4]
      else $error("count read wrong");

   // ==========================================================
   // one-shot completion; each mode ends on the waveform that meets its target
   a_oneshot_stop: assert property (@(posedge CLK) disable iff (RESET)
      (run_q && is_oneshot && seq_full && !run_request) |=> !ACQ_RUN) // see [R8]
      else $error("one-shot did not stop at its target");
   a_avg_last: assert property (@(posedge CLK) disable iff (RESET)
      (run_q && is_oneshot && mode_avg && WFM_DONE && !run_request
       && seq_next == COUNT_W'(avg_q)) |=> !ACQ_RUN) // see [R10]
      else $error("one-shot average ran past its count");
   a_env_last: assert property (@(posedge CLK) disable iff (RESET)
      (run_q && is_oneshot && mode_env && env_unlimited && WFM_DONE && !run_request
       && seq_next == COUNT_W'(arsc_pkg::ENV_INFINITE_LIMIT)) |=> !ACQ_RUN) // see [R13]
      else $error("unlimited envelope ran past its cap");
   a_env_set: assert property (@(posedge CLK) disable iff (RESET)
      (run_q && is_oneshot && mode_env && !env_unlimited && WFM_DONE && !run_request
       && seq_next == COUNT_W'(env_q)) |=> !ACQ_RUN) // see [R8]
      else $error("one-shot envelope ran past its count");
   a_smp_run: assert property (@(posedge CLK) disable iff (RESET)
      (run_q && is_oneshot && mode_smp && !WFM_DONE && !stop_wr && !press_stop)
      |=> ACQ_RUN) // see [R9]
      else $error("one-shot sample stopped without a waveform");

   // ==========================================================
   // stop control: no self stop under toggle control, a stopped engine stays stopped, stops end a one-shot early, a run write beats a press
   a_toggle_noauto: assert property (@(posedge CLK) disable iff (RESET)
      (run_q && !is_oneshot && !stop_wr && !press_stop) |=> ACQ_RUN) // see [R7]
      else $error("toggle control stopped by itself");
   a_stop_hold: assert property (@(posedge CLK) disable iff (RESET)
      (!run_q && !run_request) |=> !ACQ_RUN) // see [R1]
      else $error("engine started without a run request");
   a_early_stop: assert property (@(posedge CLK) disable iff (RESET)
      (run_q && is_oneshot && (stop_wr || press_stop)) |=> !ACQ_RUN) // see [R11]
      else $error("one-shot not ended early by a stop");
   a_panel_ignored: assert property (@(posedge CLK) disable iff (RESET)
      (start_wr && panel_press) |=> ACQ_RUN) // see [R6]
      else $error("panel press beat a run write");

   // ==========================================================
   // read port: data stand one cycle, status bit 0 mirrors the shared state
   a_rdata_idle: assert property (@(posedge CLK) disable iff (RESET)
      !RD |=> RDATA == 16'h0000) // see [R5]
      else $error("read data outside the read cycle");
   a_status_run: assert property (@(posedge CLK) disable iff (RESET)
      (RD && ADDR == arsc_pkg::OFS_STATUS) |=> RDATA[0] == $past(ACQ_RUN)) // see [R6]
      else $error("status read disagrees with running state");
endmodule : arsc_top
`default_nettype wire

//--- testbench/arsc_eng_model.sv
// acquisition engine stand-in: one waveform done pulse every gap+1 cycles
`timescale 1ns/1ps
`default_nettype none
module arsc_eng_model (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic run,
   input wire logic en,
   input wire logic [3:0] gap,
   // result
   output logic done
);
   logic [3:0] cnt_q;
   // ====================
   // pacing: the engine only digitises while the block says run
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 4'h0;
         done <= 1'b0;
      end else begin
         done <= run && en && (cnt_q == gap);
         cnt_q <= (cnt_q == gap) ? 4'h0 : cnt_q + 4'h1;
      end
   end
endmodule : arsc_eng_model
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the acquisition run/stop controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb;
   logic clk, reset, wr, rd, panel, done, run, restart, eng_en;
   logic [3:0] addr, gap;
   logic [15:0] wdata, rdata, count;
   int err_total, checks_done, n_done, target, k;
   bit run_m, one_m;
   // ====================
   // device and engine stand-in
   arsc_top arsc_top_i (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .PANEL_TOGGLE(panel), .WFM_DONE(done), .ACQ_RUN(run),
      .SEQ_RESTART(restart), .ACQ_COUNT(count));
   arsc_eng_model arsc_eng_model_i (.clk(clk), .reset(reset), .run(run), .en(eng_en),
      .gap(gap), .done(done));
   // 100 ns clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // reference: counts waveforms while running, one-shot stops at target
   always @(posedge clk) begin
      if (done && run_m) begin
         n_done++;
         if (one_m && n_done == target) begin
            run_m = 1'b0;
         end
      end
   end
   // ====================
   // bus tasks and checks
   task automatic close_out();
      if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e)
      @(posedge clk);
      #1;
      `CHK(rdata, 16'h0000)
   endtask : rd_reg
   // engine is parked first so no pulse races the comparison
   task automatic settle();
      eng_en <= 1'b0;
      repeat (12) @(posedge clk);
      #1;
      `CHK(run, run_m)
      `CHK(count, n_done[15:0])
   endtask : settle
   task automatic go();
      settle();
      wr_reg(arsc_pkg::OFS_RUN_CTRL, 16'($urandom_range(65535, 1)));
      n_done = 0;
      run_m = 1'b1;
      `CHK(restart, 1'b1)
      `CHK(run, 1'b1)
      `CHK(count, 16'h0000)
      @(posedge clk);
      #1;
      `CHK(restart, 1'b0)
   endtask : go
   task automatic press();
      settle();
      @(posedge clk);
      panel <= 1'b1;
      repeat (8) @(posedge clk);
      panel <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      run_m = !run_m;
      if (run_m) n_done = 0;
      `CHK(run, run_m)
      `CHK(count, n_done[15:0])
   endtask : press
   task automatic one_shot(input logic [1:0] m, input logic [3:0] ra, input logic [9:0] n,
         input int t);
      wr_reg(arsc_pkg::OFS_STOP_SEL, 16'h0001);
      wr_reg(arsc_pkg::OFS_ACQ_MODE, {14'h0000, m});
      wr_reg(ra, {6'h00, n});
      one_m = 1'b1;
      target = t;
      go();
      eng_en <= 1'b1;
      for (int i = 0; i < 5000 && run; i++) @(posedge clk);
      settle();
   endtask : one_shot
   // ====================
   // main sequence
   initial begin
      void'($urandom(32'hb870_cc3f));
      {wr, rd, panel, eng_en, run_m, one_m} = '0;
      addr = 4'h0;
      wdata = 16'h0000;
      gap = 4'($urandom_range(7, 4));
      k = $urandom_range(6, 1);
      reset = 1'b1;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rd_reg(arsc_pkg::OFS_RUN_CTRL, 16'h0000);
      rd_reg(arsc_pkg::OFS_AVG_CNT, {6'h00, arsc_pkg::RST_AVG_CNT});
      rd_reg(4'hf, 16'h0000);
      // toggle-controlled: keeps running until told otherwise
      go();
      eng_en <= 1'b1;
      repeat (60) @(posedge clk);
      settle();
      rd_reg(arsc_pkg::OFS_RUN_CTRL, 16'h0001);
      rd_reg(arsc_pkg::OFS_ACQ_COUNT, n_done[15:0]);
      go();
      wr_reg(arsc_pkg::OFS_RUN_CTRL, 16'h0000);
      run_m = 1'b0;
      `CHK(run, 1'b0)
      press();
      press();
      // one-shot in every mode; counts kept to powers of two from 2 to 512, or zero for unlimited envelope
      one_shot(arsc_pkg::MODE_SAMPLE, arsc_pkg::OFS_AVG_CNT, 10'h010, 1);
      one_shot(arsc_pkg::MODE_AVERAGE, arsc_pkg::OFS_AVG_CNT, 10'(1 << k), 1 << k);
      one_shot(arsc_pkg::MODE_ENVELOPE, arsc_pkg::OFS_ENV_CNT, 10'h008, 8);
      one_shot(arsc_pkg::MODE_ENVELOPE, arsc_pkg::OFS_ENV_CNT, 10'h000, 513);
      // early end of a one-shot by stop write, then by panel
      go();
      eng_en <= 1'b1;
      repeat (30) @(posedge clk);
      settle();
      wr_reg(arsc_pkg::OFS_RUN_CTRL, 16'h0000);
      run_m = 1'b0;
      `CHK(run, 1'b0)
      go();
      eng_en <= 1'b1;
      repeat (30) @(posedge clk);
      press();
      // reset in mid-run: state and settings go back to their reset values
      go();
      eng_en <= 1'b1;
      repeat (20) @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      run_m = 1'b0;
      one_m = 1'b0;
      n_done = 0;
      #1;
      `CHK(run, 1'b0)
      `CHK(count, 16'h0000)
      rd_reg(arsc_pkg::OFS_STOP_SEL, 16'h0000);
      go();
      close_out();
   end
   // watchdog: the sequence needs well under 15000 cycles
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      close_out();
   end
endmodule : tb
`default_nettype wire
